/* File: rtl/sptr_pkg.sv */
// Package for the supervisor threshold and timing register bank.
// Assumes one clock domain and a serial front end that issues byte requests.
`default_nettype none

package sptr_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] IGN_OFF_THR_OFS = 8'h04;
  localparam logic [7:0] LOW_RAIL_THR_OFS = 8'h05;
  localparam logic [7:0] MID_RAIL_THR_OFS = 8'h06;
  localparam logic [7:0] BAT_HOLD_OFS = 8'h07;
  localparam logic [7:0] BAT_DELAY_OFS = 8'h08;
  localparam logic [7:0] IGN_ON_HOLD_OFS = 8'h09;
  localparam logic [7:0] IGN_OFF_DELAY_OFS = 8'h0a;
  localparam logic [7:0] RST_HOLD_OFS = 8'h0b;
  localparam logic [7:0] FIRST_OFS = IGN_OFF_THR_OFS;
  localparam int NUM_REGS = 8;

  // ==========================================================
  // Field layout: all fields start at bit 0
  localparam int FIELD_LSB = 0;
  localparam int THR4_WIDTH = 4;
  localparam int CODE3_WIDTH = 3;
  localparam logic [7:0] THR4_MASK = 8'h0f;
  localparam logic [7:0] CODE3_MASK = 8'h07;

  // ==========================================================
  // Non-programmed power-on values and what code zero selects
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam int IGN_OFF_THR_MV = 6950;
  localparam int LOW_RAIL_THR_MV = 2930;
  localparam int MID_RAIL_THR_MV = 7540;
  localparam int BAT_HOLD_MS = 200;
  localparam int BAT_DELAY_MS = 1200;
  localparam int IGN_ON_HOLD_MS = 10;
  localparam int IGN_OFF_DELAY_MS = 100;
  localparam int RST_HOLD_MS = 200;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } sptr_req_t;

  typedef struct packed {
    logic [3:0] ign_off_thr;
    logic [2:0] low_rail_thr;
    logic [2:0] mid_rail_thr;
    logic [2:0] battery_fault_hold_time;
    logic [2:0] battery_fault_delay_time;
    logic [2:0] ignition_on_hold_time;
    logic [2:0] ignition_off_delay_time;
    logic [2:0] reset_hold_time;
  } sptr_cfg_t;

  typedef logic [NUM_REGS-1:0][7:0] sptr_image_t;

endpackage

`default_nettype wire

/* File: rtl/sptr_regs.sv */
// Eight byte-wide threshold and timing registers of a voltage supervisor.
// Assumes a serial front end issuing one-cycle read/write strobes and an
// OTP reader that presents the factory image with a one-cycle load pulse.
//
// Notes on behaviour
// - Ignition off threshold: 4-bit code, 6.95 V default
// - Low rail reset threshold: 3-bit, 2.93 V default
// - Mid rail reset threshold: 3-bit, 7.54 V default
// - Battery fault shutdown hold code, 200 ms default
// - Battery fault shutdown delay code, 1200 ms default
// - Ignition on shutdown hold code, 10 ms default
// - Ignition off shutdown delay code, 100 ms default
// - Reset output hold code, 200 ms default
// - Same address for reading and writing
// - Defaults load from factory OTP after power-up
`default_nettype none

module sptr_regs (
  input wire logic mclk,
  input wire logic rst,
  input wire sptr_pkg::sptr_req_t req,
  input wire logic otp_load,
  input wire sptr_pkg::sptr_image_t otp_image,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic otp_done,
  output sptr_pkg::sptr_cfg_t cfg
);

  // ==========================================================
  // Decoding
  function automatic logic [7:0] field_mask(input int idx);
    begin
      if (idx == 0) begin
        field_mask = sptr_pkg::THR4_MASK;
      end else begin
        field_mask = sptr_pkg::CODE3_MASK;
      end
    end
  endfunction

  function automatic logic hit(input logic [7:0] addr);
    logic [7:0] rel;
    begin
      // Offsets below the map wrap in the subtraction, hence the lower bound
      rel = addr - sptr_pkg::FIRST_OFS;
      hit = (addr >= sptr_pkg::FIRST_OFS) && (rel < 8'(sptr_pkg::NUM_REGS));
    end
  endfunction

  logic [7:0] regs [sptr_pkg::NUM_REGS];
  logic [7:0] next_regs [sptr_pkg::NUM_REGS];
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic next_otp_done;
  logic [2:0] rd_idx;

  assign rd_idx = 3'(req.addr - sptr_pkg::FIRST_OFS);

  // ==========================================================
  // Storage
  // A load from OTP outranks a host write in the same cycle, since the
  // factory image must be in place before the host settings take over.
  genvar gi;
  generate
    for (gi = 0; gi < sptr_pkg::NUM_REGS; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (otp_load) begin
          next_regs[gi] = otp_image[gi] & field_mask(gi);
        end else if (req.we && hit(req.addr) && rd_idx == 3'(gi)) begin
          next_regs[gi] = req.wdata & field_mask(gi);
        end
      end

      always_ff @(posedge mclk) begin
        if (rst) begin
          regs[gi] <= sptr_pkg::REG_RESET;
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read port
  // Unmapped offsets answer zero so a stray read never looks like a code.
  always_comb begin
    next_reg_rvalid = req.re;
    next_reg_rdata = sptr_pkg::RDATA_RESET;
    if (req.re && hit(req.addr)) begin
      next_reg_rdata = regs[rd_idx];
    end
    // Sticky until reset, so software can tell a blank part from a loaded one
    next_otp_done = otp_done | otp_load;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= sptr_pkg::RDATA_RESET;
      reg_rvalid <= 1'b0;
      otp_done <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      otp_done <= next_otp_done;
    end
  end

  // ==========================================================
  // Codes handed to the comparators and timers
  // Code zero selects 6.95 V, 2.93 V, 7.54 V and 200, 1200, 10, 100, 200 ms.
  always_comb begin
    cfg.ign_off_thr = regs[0][sptr_pkg::THR4_WIDTH-1:0];
    cfg.low_rail_thr = regs[1][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.mid_rail_thr = regs[2][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.battery_fault_hold_time = regs[3][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.battery_fault_delay_time = regs[4][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.ignition_on_hold_time = regs[5][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.ignition_off_delay_time = regs[6][sptr_pkg::CODE3_WIDTH-1:0];
    cfg.reset_hold_time = regs[7][sptr_pkg::CODE3_WIDTH-1:0];
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ign_thr_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::IGN_OFF_THR_OFS
    |=> cfg.ign_off_thr == $past(req.wdata[3:0]))
    else $error("ignition threshold write not applied");

  low_thr_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::LOW_RAIL_THR_OFS
    |=> cfg.low_rail_thr == $past(req.wdata[2:0]))
    else $error("low rail threshold write not applied");

  mid_thr_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::MID_RAIL_THR_OFS
    |=> cfg.mid_rail_thr == $past(req.wdata[2:0]))
    else $error("mid rail threshold write not applied");

  bat_hold_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::BAT_HOLD_OFS
    |=> cfg.battery_fault_hold_time == $past(req.wdata[2:0]))
    else $error("battery hold write not applied");

  bat_delay_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::BAT_DELAY_OFS
    |=> cfg.battery_fault_delay_time == $past(req.wdata[2:0]))
    else $error("battery delay write not applied");

  ign_hold_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::IGN_ON_HOLD_OFS
    |=> cfg.ignition_on_hold_time == $past(req.wdata[2:0]))
    else $error("ignition hold write not applied");

  ign_delay_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::IGN_OFF_DELAY_OFS
    |=> cfg.ignition_off_delay_time == $past(req.wdata[2:0]))
    else $error("ignition delay write not applied");

  rst_hold_write_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::RST_HOLD_OFS
    |=> cfg.reset_hold_time == $past(req.wdata[2:0]))
    else $error("reset hold write not applied");

  same_addr_a: assert property (
    req.we && !otp_load && hit(req.addr) ##1
    req.re && !req.we && !otp_load && req.addr == $past(req.addr)
    |=> reg_rvalid && reg_rdata == ($past(req.wdata, 2) & field_mask(int'($past(rd_idx)))))
    else $error("read back differs from write at same address");

  otp_load_a: assert property (
    otp_load |=> cfg.reset_hold_time == $past(otp_image[7][2:0])
    && cfg.ign_off_thr == $past(otp_image[0][3:0]) && otp_done)
    else $error("OTP image not loaded");

  reserved_zero_a: assert property (
    reg_rvalid |-> reg_rdata[7:4] == 4'h0
    && ($past(req.addr) == sptr_pkg::IGN_OFF_THR_OFS || reg_rdata[3] == 1'b0))
    else $error("reserved bits read non-zero");

  read_timing_a: assert property (
    req.re |=> reg_rvalid ##1 (reg_rvalid == $past(req.re)))
    else $error("read answer timing wrong");

  unmapped_a: assert property (
    req.re && !hit(req.addr) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  hold_value_a: assert property (
    !req.we && !otp_load |=> $stable(cfg))
    else $error("configuration changed without a write");

  thr_kept_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::RST_HOLD_OFS
    |=> $stable(cfg.ign_off_thr))
    else $error("write disturbed the ignition threshold");

  hold_kept_a: assert property (
    req.we && !otp_load && req.addr == sptr_pkg::IGN_OFF_THR_OFS
    |=> $stable(cfg.reset_hold_time))
    else $error("write disturbed the reset hold code");

  unmapped_write_a: assert property (
    req.we && !otp_load && !hit(req.addr) |=> $stable(cfg))
    else $error("write outside the map changed a code");

  idle_rdata_a: assert property (
    !req.re |=> !reg_rvalid && reg_rdata == sptr_pkg::RDATA_RESET)
    else $error("read answer without a read");

  rvalid_pulse_a: assert property (
    reg_rvalid |-> $past(req.re))
    else $error("read answer without a request");

  // ==========================================================
  // Read back against the codes in use
  // A read with no write or load beside it must show the code the timers
  // see, with the reserved bits as zero.

  ign_thr_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::IGN_OFF_THR_OFS
    |=> reg_rdata == {4'h0, cfg.ign_off_thr})
    else $error("ignition threshold read differs");

  low_thr_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::LOW_RAIL_THR_OFS
    |=> reg_rdata == {5'h00, cfg.low_rail_thr})
    else $error("low rail threshold read differs");

  mid_thr_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::MID_RAIL_THR_OFS
    |=> reg_rdata == {5'h00, cfg.mid_rail_thr})
    else $error("mid rail threshold read differs");

  bat_hold_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::BAT_HOLD_OFS
    |=> reg_rdata == {5'h00, cfg.battery_fault_hold_time})
    else $error("battery hold read differs");

  bat_delay_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::BAT_DELAY_OFS
    |=> reg_rdata == {5'h00, cfg.battery_fault_delay_time})
    else $error("battery delay read differs");

  ign_hold_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::IGN_ON_HOLD_OFS
    |=> reg_rdata == {5'h00, cfg.ignition_on_hold_time})
    else $error("ignition hold read differs");

  ign_delay_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::IGN_OFF_DELAY_OFS
    |=> reg_rdata == {5'h00, cfg.ignition_off_delay_time})
    else $error("ignition delay read differs");

  rst_hold_read_a: assert property (
    req.re && !req.we && !otp_load && req.addr == sptr_pkg::RST_HOLD_OFS
    |=> reg_rdata == {5'h00, cfg.reset_hold_time})
    else $error("reset hold read differs");

  // ==========================================================
  // Reset and factory load
  // The default disable would hide the reset cycles, so it is switched off.
  reset_clear_a: assert property (
    disable iff (1'b0)
    rst |=> cfg == '0 && !otp_done && !reg_rvalid && reg_rdata == sptr_pkg::RDATA_RESET)
    else $error("reset left state behind");

  otp_all_fields_a: assert property (
    otp_load |=> cfg.low_rail_thr == $past(otp_image[1][2:0])
    && cfg.mid_rail_thr == $past(otp_image[2][2:0])
    && cfg.battery_fault_hold_time == $past(otp_image[3][2:0])
    && cfg.battery_fault_delay_time == $past(otp_image[4][2:0])
    && cfg.ignition_on_hold_time == $past(otp_image[5][2:0])
    && cfg.ignition_off_delay_time == $past(otp_image[6][2:0]))
    else $error("OTP image field not loaded");

  otp_done_sticky_a: assert property (
    otp_done |=> otp_done)
    else $error("load flag dropped without reset");

  otp_done_set_a: assert property (
    !otp_done && !otp_load |=> !otp_done)
    else $error("load flag set without a load");

  // Reserved bits are checked in the flops as well as on reads.
  generate
    for (gi = 0; gi < sptr_pkg::NUM_REGS; gi++) begin : g_chk
      reserved_store_a: assert property (
        @(posedge mclk) disable iff (rst)
        (regs[gi] & ~field_mask(gi)) == 8'h00)
        else $error("reserved bits stored non-zero");
    end
  endgenerate

  write_read_c: cover property (
    req.we && hit(req.addr) ##1 req.re && req.addr == $past(req.addr));
  otp_then_write_c: cover property (otp_load ##[1:4] req.we && hit(req.addr));
  otp_write_clash_c: cover property (otp_load && req.we && hit(req.addr));
  unmapped_read_c: cover property (req.re && !hit(req.addr));
  read_burst_c: cover property (req.re ##1 req.re);

endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the threshold and timing register bank.
// Assumes the design package and register module are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst, otp_load, reg_rvalid, otp_done;
  logic [7:0] reg_rdata, d, a;
  sptr_pkg::sptr_req_t req;
  sptr_pkg::sptr_image_t otp_image;
  sptr_pkg::sptr_cfg_t cfg;
  int errors, num_checks;
  logic [7:0] mdl [8];
  sptr_regs dut_u (.mclk(mclk), .rst(rst), .req(req), .otp_load(otp_load),
    .otp_image(otp_image), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .otp_done(otp_done), .cfg(cfg));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Model and comparisons
  function automatic logic [7:0] msk(input int i, input logic [7:0] v);
    return (i == 0) ? (v & 8'h0f) : (v & 8'h07);
  endfunction
  function automatic logic [7:0] ex(input logic [7:0] ad);
    return (ad >= 8'h04 && ad <= 8'h0b) ? mdl[ad - 8'h04] : 8'h00;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg();
    chk(8'(cfg.ign_off_thr), mdl[0]);
    chk(8'(cfg.low_rail_thr), mdl[1]);
    chk(8'(cfg.mid_rail_thr), mdl[2]);
    chk(8'(cfg.battery_fault_hold_time), mdl[3]);
    chk(8'(cfg.battery_fault_delay_time), mdl[4]);
    chk(8'(cfg.ignition_on_hold_time), mdl[5]);
    chk(8'(cfg.ignition_off_delay_time), mdl[6]);
    chk(8'(cfg.reset_hold_time), mdl[7]);
  endtask
  // ==========================================================
  // Register port tasks: driven one step after the edge and held until the
  // next request takes over, so no strobe is written twice in one step
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    req.addr = ad;
    req.wdata = v;
    req.we = 1'b1;
    req.re = 1'b0;
    @(posedge mclk);
    #1;
    if (ad >= 8'h04 && ad <= 8'h0b) mdl[ad - 8'h04] = msk(int'(ad) - 4, v);
  endtask
  task automatic rd(input logic [7:0] ad);
    req.addr = ad;
    req.we = 1'b0;
    req.re = 1'b1;
    @(posedge mclk);
    #1;
    chk(8'(reg_rvalid), 8'h01);
    chk(reg_rdata, ex(ad));
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Run needs about 150 cycles; the limit leaves a wide margin
  initial begin
    #40000;
    errors++;
    wrap_up();
  end
  // ==========================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    otp_load = 1'b0;
    req = '0;
    otp_image = '0;
    errors = 0;
    num_checks = 0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    void'($urandom(32'h996f469c));
    repeat (6) @(posedge mclk);
    #1 rst = 1'b0;
    // Power-on codes, neighbours of the map read zero
    for (int i = 3; i < 13; i++) rd(8'(i));
    chk_cfg();
    chk(8'(otp_done), 8'h00);
    // Random bytes, reserved bits and unmapped offsets included
    repeat (60) begin
      a = 8'($urandom_range(12, 3));
      wr(a, 8'($urandom));
      rd(a);
      chk_cfg();
    end
    // Write and read at one edge: read sees the old byte
    d = ex(8'h07);
    req.addr = 8'h07;
    req.wdata = 8'hfd;
    req.we = 1'b1;
    req.re = 1'b1;
    @(posedge mclk);
    #1;
    chk(8'(reg_rvalid), 8'h01);
    chk(reg_rdata, d);
    mdl[3] = 8'h05;
    chk_cfg();
    // Factory image load beats a host write in the same cycle
    foreach (otp_image[i]) otp_image[i] = 8'($urandom);
    req.addr = 8'h04;
    req.wdata = 8'hff;
    req.re = 1'b0;
    otp_load = 1'b1;
    @(posedge mclk);
    #1 otp_load = 1'b0;
    foreach (mdl[i]) mdl[i] = msk(i, otp_image[i]);
    chk(8'(otp_done), 8'h01);
    chk_cfg();
    wr(8'h0b, 8'($urandom));
    for (int i = 4; i < 12; i++) rd(8'(i));
    // Second reset in mid-run returns the non-programmed values
    req.re = 1'b0;
    rst = 1'b1;
    @(posedge mclk);
    #1 rst = 1'b0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    chk_cfg();
    chk(8'(otp_done), 8'h00);
    rd(8'h04);
    wrap_up();
  end
endmodule
`default_nettype wire
